// >>> rtl/rac_regs.svh
// Register map, field positions, reset values and timing constants of restart and alarm control
`ifndef RAC_REGS_SVH
`define RAC_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RAC_OFF_CTRL 4'h0
`define RAC_OFF_STATUS 4'h4
`define RAC_OFF_IRQ_STAT 4'h8
`define RAC_OFF_IRQ_MASK 4'hc
`define RAC_ADDR_LSB 2
`define RAC_ADDR_MSB 3

// ----------------------------------------
// Control fields
// ----------------------------------------
`define RAC_CTRL_MODE_LSB 0
`define RAC_CTRL_MODE_MSB 2
`define RAC_CTRL_RSTDIS_BIT 3
`define RAC_CTRL_RESET 4'h8

// ----------------------------------------
// Status fields
// ----------------------------------------
`define RAC_ST_READY 0
`define RAC_ST_START_DIS 1
`define RAC_ST_RESTART_DIS 2
`define RAC_ST_SEL_FAULT 3
`define RAC_ST_BUSY 4
`define RAC_ST_PAIR_LSB 5
`define RAC_ST_PAIR_MSB 8

// ----------------------------------------
// Interrupt bits
// ----------------------------------------
`define RAC_IRQ_W 5
`define RAC_IRQ_VALID 0
`define RAC_IRQ_REJECT 1
`define RAC_IRQ_NEAR 2
`define RAC_IRQ_SEL 3
`define RAC_IRQ_ERROR 4
`define RAC_IRQ_RESET 5'h00

// ----------------------------------------
// Restart pulse window and field pair settings
// ----------------------------------------
`define RAC_CLK_KHZ 100000
`define RAC_RESTART_MIN_MS 120
`define RAC_RESTART_MAX_MS 3000
`define RAC_MAX_PAIRS 2
`define RAC_PAIR_DEFAULT 4'h1

`endif

// >>> rtl/rac_pkg.sv
// Types shared by the restart and alarm control design
package rac_pkg;

  // Device condition inputs from the scanner core
  typedef struct packed {
    logic dev_error;
    logic warning;
    logic far_obj;
    logic near_obj;
  } rac_dev_in_t;

  // Configurable alarm output functions
  typedef enum logic [2:0] {
    RAC_AL_FAR = 3'h0,
    RAC_AL_WARN = 3'h1,
    RAC_AL_FAR_WARN = 3'h2,
    RAC_AL_NONE = 3'h3,
    RAC_AL_ERROR = 3'h4
  } rac_alarm_mode_t;

  // Restart pulse measurement states
  typedef enum logic [2:0] {
    RAC_RS_IDLE = 3'b001,
    RAC_RS_COUNT = 3'b010,
    RAC_RS_LONG = 3'b100
  } rac_rs_state_t;

endpackage

// >>> rtl/rac_restart_timer.sv
// Restart input pulse width measurement
`timescale 1ns/1ns
`include "rac_regs.svh"

module rac_restart_timer
  import rac_pkg::*;
#(
  parameter int unsigned MIN_CYC = 1,
  parameter int unsigned MAX_CYC = 2
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Restart level and gate
  input wire logic arm,
  input wire logic pin,
  // Results
  output logic busy,
  output logic valid_q,
  output logic reject_q
);

  rac_rs_state_t state_q;
  logic [31:0] cnt_q;

  assign busy = pin & arm;

  // ----------------------------------------
  // Pulse measurement
  // ----------------------------------------
  // Losing readiness aborts a pulse without verdict so it can never release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= RAC_RS_IDLE;
      cnt_q <= 32'h0;
      valid_q <= 1'b0;
      reject_q <= 1'b0;
    end else begin
      valid_q <= 1'b0;
      reject_q <= 1'b0;
      unique case (state_q)
        RAC_RS_IDLE: begin
          cnt_q <= 32'h1;
          if (busy) begin
            state_q <= RAC_RS_COUNT;
          end
        end
        RAC_RS_COUNT: begin
          if (!arm) begin
            state_q <= RAC_RS_IDLE;
          end else if (!pin) begin
            state_q <= RAC_RS_IDLE;
            valid_q <= (cnt_q >= MIN_CYC);
            reject_q <= (cnt_q < MIN_CYC);
          end else if (cnt_q >= MAX_CYC) begin
            state_q <= RAC_RS_LONG;
          end else begin
            cnt_q <= cnt_q + 32'h1;
          end
        end
        RAC_RS_LONG: begin
          if (!arm || !pin) begin
            state_q <= RAC_RS_IDLE;
            reject_q <= arm;
          end
        end
        default: begin
          state_q <= RAC_RS_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> rtl/rac_top.sv
// Restart and alarm output control with AHB-Lite register slave
//
// What this block does
// - Device error forces every switching output low
// - Error alarm low on any warning or fault
// - Valid restart pulse clears restart-disable latch if near field clear
// - Valid restart pulse clears start-disable latch
// - Restart acted on only while ready
// - During restart: shutdown outputs off, LED3 red
// - Green LED only when near field clear
// - Ready needs supply and one select active
// - No select input means field pair one
// - Bad select combination: warning, shutdown outputs off
// - Over two pairs: fault on configurable alarm
// - Shutdown outputs high only with near field clear
`timescale 1ns/1ns
`include "rac_regs.svh"

module rac_top
  import rac_pkg::*;
#(
  parameter int unsigned RESTART_MIN_CYC = `RAC_RESTART_MIN_MS * `RAC_CLK_KHZ,
  parameter int unsigned RESTART_MAX_CYC = `RAC_RESTART_MAX_MS * `RAC_CLK_KHZ
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Scanner core conditions and supply
  input wire rac_dev_in_t dev_in,
  input wire logic supply_ok,
  // Field pair selects and restart button
  input wire logic field_pair_sel_1,
  input wire logic field_pair_sel_2,
  input wire logic field_pair_sel_3,
  input wire logic field_pair_sel_4,
  input wire logic restart_pin,
  // Switching outputs and indicators
  output logic near_shutdown_out_a,
  output logic near_shutdown_out_b,
  output logic config_alarm_out,
  output logic error_alarm_out,
  output logic led3_red,
  output logic led_green,
  output logic [3:0] field_pair_active,
  // Interrupt
  output logic irq
);

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic logic [2:0] sel_count(input logic [3:0] s);
    sel_count = {2'b00, s[0]} + {2'b00, s[1]} + {2'b00, s[2]} + {2'b00, s[3]};
  endfunction

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  // ----------------------------------------
  // Select decode and readiness
  // ----------------------------------------
  logic [3:0] sel;
  logic sel_fault;
  logic ready;
  assign sel = {field_pair_sel_4, field_pair_sel_3, field_pair_sel_2, field_pair_sel_1};
  assign sel_fault = sel_count(sel) > 3'(`RAC_MAX_PAIRS);
  assign ready = supply_ok && (sel != 4'h0);

  // ----------------------------------------
  // Restart pulse timer
  // ----------------------------------------
  logic rs_busy;
  logic rs_valid;
  logic rs_reject;

  rac_restart_timer #(
    .MIN_CYC(RESTART_MIN_CYC),
    .MAX_CYC(RESTART_MAX_CYC)
  ) u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .arm(ready),
    .pin(restart_pin),
    .busy(rs_busy),
    .valid_q(rs_valid),
    .reject_q(rs_reject)
  );

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [3:0] ctrl_q;
  logic [`RAC_IRQ_W-1:0] irq_st_q;
  logic [`RAC_IRQ_W-1:0] irq_st_d;
  logic [`RAC_IRQ_W-1:0] irq_mask_q;
  logic start_dis_q;
  logic restart_dis_q;
  rac_alarm_mode_t mode;
  assign mode = rac_alarm_mode_t'(ctrl_q[`RAC_CTRL_MODE_MSB:`RAC_CTRL_MODE_LSB]);

  // ----------------------------------------
  // Disable latches
  // ----------------------------------------
  // Start-disable is re-armed whenever supply drops, as after a fresh start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_dis_q <= 1'b1;
    end else if (!supply_ok) begin
      start_dis_q <= 1'b1;
    end else if (rs_valid) begin
      start_dis_q <= 1'b0;
    end
  end

  // A detection still present wins over the release in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      restart_dis_q <= 1'b0;
    end else if (!ctrl_q[`RAC_CTRL_RSTDIS_BIT]) begin
      restart_dis_q <= 1'b0;
    end else if (dev_in.near_obj) begin
      restart_dis_q <= 1'b1;
    end else if (rs_valid) begin
      restart_dis_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Switching outputs
  // ----------------------------------------
  logic near_d;
  logic cfg_ok;
  assign near_d = !dev_in.dev_error && ready && !sel_fault && !dev_in.near_obj
    && !start_dis_q && !restart_dis_q && !rs_busy;

  always_comb begin
    unique case (mode)
      RAC_AL_FAR: cfg_ok = !dev_in.far_obj;
      RAC_AL_WARN: cfg_ok = !dev_in.warning;
      RAC_AL_FAR_WARN: cfg_ok = !dev_in.far_obj && !dev_in.warning;
      RAC_AL_NONE: cfg_ok = 1'b1;
      RAC_AL_ERROR: cfg_ok = 1'b1;
      default: cfg_ok = 1'b1;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      near_shutdown_out_a <= 1'b0;
      near_shutdown_out_b <= 1'b0;
      config_alarm_out <= 1'b0;
      error_alarm_out <= 1'b0;
    end else begin
      near_shutdown_out_a <= near_d;
      near_shutdown_out_b <= near_d;
      config_alarm_out <= cfg_ok && !sel_fault && !dev_in.dev_error;
      error_alarm_out <= !(dev_in.dev_error || dev_in.warning || sel_fault);
    end
  end

  // ----------------------------------------
  // Indicators and active pair
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      led3_red <= 1'b0;
      led_green <= 1'b0;
      field_pair_active <= 4'h0;
    end else begin
      led3_red <= rs_busy;
      led_green <= near_d;
      field_pair_active <= (sel == 4'h0) ? `RAC_PAIR_DEFAULT : sel;
    end
  end

  // ----------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------
  logic ap_valid;
  logic dp_write_q;
  logic [3:0] dp_addr_q;
  logic [31:0] status_w;
  logic wr_irq_st;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ap_valid = hsel && htrans[1] && hready;
  assign wr_irq_st = dp_write_q && hit(dp_addr_q, `RAC_OFF_IRQ_STAT);

  always_comb begin
    status_w = 32'h0;
    status_w[`RAC_ST_READY] = ready;
    status_w[`RAC_ST_START_DIS] = start_dis_q;
    status_w[`RAC_ST_RESTART_DIS] = restart_dis_q;
    status_w[`RAC_ST_SEL_FAULT] = sel_fault;
    status_w[`RAC_ST_BUSY] = rs_busy;
    status_w[`RAC_ST_PAIR_MSB:`RAC_ST_PAIR_LSB] = field_pair_active;
  end

  // Read data is captured in the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write_q <= 1'b0;
      dp_addr_q <= 4'h0;
      hrdata <= 32'h0;
    end else begin
      dp_write_q <= ap_valid && hwrite;
      dp_addr_q <= {haddr[`RAC_ADDR_MSB:`RAC_ADDR_LSB], 2'b00};
      hrdata <= 32'h0;
      if (ap_valid && !hwrite) begin
        unique case (1'b1)
          hit({haddr[`RAC_ADDR_MSB:`RAC_ADDR_LSB], 2'b00}, `RAC_OFF_CTRL): hrdata <= {28'h0, ctrl_q};
          hit({haddr[`RAC_ADDR_MSB:`RAC_ADDR_LSB], 2'b00}, `RAC_OFF_STATUS): hrdata <= status_w;
          hit({haddr[`RAC_ADDR_MSB:`RAC_ADDR_LSB], 2'b00}, `RAC_OFF_IRQ_STAT): hrdata <= {27'h0, irq_st_q};
          hit({haddr[`RAC_ADDR_MSB:`RAC_ADDR_LSB], 2'b00}, `RAC_OFF_IRQ_MASK): hrdata <= {27'h0, irq_mask_q};
          default: hrdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `RAC_CTRL_RESET;
    end else if (dp_write_q && hit(dp_addr_q, `RAC_OFF_CTRL)) begin
      ctrl_q <= hwdata[3:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_q <= `RAC_IRQ_RESET;
    end else if (dp_write_q && hit(dp_addr_q, `RAC_OFF_IRQ_MASK)) begin
      irq_mask_q <= hwdata[`RAC_IRQ_W-1:0];
    end
  end

  // ----------------------------------------
  // Interrupt events, set wins over clear
  // ----------------------------------------
  logic near_obj_q;
  logic sel_fault_q;
  logic dev_error_q;
  logic [`RAC_IRQ_W-1:0] ev;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      near_obj_q <= 1'b0;
      sel_fault_q <= 1'b0;
      dev_error_q <= 1'b0;
    end else begin
      near_obj_q <= dev_in.near_obj;
      sel_fault_q <= sel_fault;
      dev_error_q <= dev_in.dev_error;
    end
  end

  always_comb begin
    ev = '0;
    ev[`RAC_IRQ_VALID] = rs_valid;
    ev[`RAC_IRQ_REJECT] = rs_reject;
    ev[`RAC_IRQ_NEAR] = dev_in.near_obj && !near_obj_q;
    ev[`RAC_IRQ_SEL] = sel_fault && !sel_fault_q;
    ev[`RAC_IRQ_ERROR] = dev_in.dev_error && !dev_error_q;
    irq_st_d = irq_st_q;
    if (wr_irq_st) begin
      irq_st_d = irq_st_q & ~hwdata[`RAC_IRQ_W-1:0];
    end
    irq_st_d = irq_st_d | ev;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_st_q <= `RAC_IRQ_RESET;
    end else begin
      irq_st_q <= irq_st_d;
    end
  end

  assign irq = |(irq_st_q & irq_mask_q);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  chk_error_all_low: assert property (
    dev_in.dev_error |=> !near_shutdown_out_a && !near_shutdown_out_b && !config_alarm_out && !error_alarm_out)
    else $error("device error did not force outputs low");
  chk_warn_alarm: assert property (
    dev_in.warning |=> !error_alarm_out) else $error("warning not shown on error alarm");
  chk_restart_clear: assert property (
    rs_valid && !dev_in.near_obj && ctrl_q[`RAC_CTRL_RSTDIS_BIT] |=> !restart_dis_q)
    else $error("valid restart kept restart-disable");
  chk_start_clear: assert property (
    rs_valid && supply_ok |=> !start_dis_q) else $error("valid restart kept start-disable");
  chk_valid_ready: assert property (
    rs_valid |-> $past(ready)) else $error("restart accepted while not ready");
  chk_busy_off: assert property (
    restart_pin && ready |=> !near_shutdown_out_a && !near_shutdown_out_b && led3_red)
    else $error("restart in progress but outputs on or lamp dark");
  chk_green_clear: assert property (
    led_green |-> !$past(dev_in.near_obj)) else $error("green lamp with object in near field");
  chk_not_ready_off: assert property (
    !ready |=> !near_shutdown_out_a) else $error("shutdown output on while not ready");
  chk_default_pair: assert property (
    sel == 4'h0 |=> field_pair_active == `RAC_PAIR_DEFAULT) else $error("pair one not used without selects");
  chk_sel_fault: assert property (
    sel_count(sel) > 3'd2 |=> !error_alarm_out && !config_alarm_out && !near_shutdown_out_a && !near_shutdown_out_b)
    else $error("select fault not reported");
  chk_near_obj: assert property (
    dev_in.near_obj |=> !near_shutdown_out_a && !near_shutdown_out_b)
    else $error("shutdown output on with near object");
  chk_reject_keep: assert property (
    rs_reject && start_dis_q && supply_ok |=> start_dis_q) else $error("rejected pulse changed a latch");
  chk_latch_low: assert property (
    start_dis_q || restart_dis_q |=> !near_shutdown_out_a) else $error("shutdown output on while latched");

endmodule

// >>> dv/rac_button_model.sv
// Operator restart push button model facing restart and alarm control
`timescale 1ns/1ns

module rac_button_model (
  // Clock
  input wire logic hclk,
  // Button contact
  output logic restart_pin
);
  initial restart_pin = 1'b0;

  // ----------------------------------------
  // Press
  // ----------------------------------------
  // Only this fixed button drives the pin; the hold length is given by the bench,
  // so out-of-window presses happen only when a scenario asks for them
  task automatic press(input int n);
    @(posedge hclk);
    restart_pin <= 1'b1;
    repeat (n) @(posedge hclk);
    restart_pin <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask
endmodule

// >>> dv/restart_and_alarm_output_control_test.sv
// Self-checking testbench of restart and alarm output control
`timescale 1ns/1ns
`include "rac_regs.svh"

`define CHK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module restart_and_alarm_output_control_test import rac_pkg::*;;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  // Short restart window keeps the run brief
  localparam int MINC = 5;
  localparam int MAXC = 20;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, restart_pin;
  logic [31:0] hrdata;
  logic [31:0] rd;
  rac_dev_in_t dev_in = 4'h0;
  logic supply_ok = 1'b1;
  logic [3:0] sel = 4'h0;
  logic near_shutdown_out_a, near_shutdown_out_b, config_alarm_out, error_alarm_out;
  logic led3_red, led_green, irq;
  logic [3:0] field_pair_active;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;

  rac_button_model rac_button_model_i (.hclk(hclk), .restart_pin(restart_pin));

  rac_top #(.RESTART_MIN_CYC(MINC), .RESTART_MAX_CYC(MAXC)) rac_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dev_in(dev_in),
    .supply_ok(supply_ok), .field_pair_sel_1(sel[0]), .field_pair_sel_2(sel[1]),
    .field_pair_sel_3(sel[2]), .field_pair_sel_4(sel[3]), .restart_pin(restart_pin),
    .near_shutdown_out_a(near_shutdown_out_a), .near_shutdown_out_b(near_shutdown_out_b),
    .config_alarm_out(config_alarm_out), .error_alarm_out(error_alarm_out),
    .led3_red(led3_red), .led_green(led_green), .field_pair_active(field_pair_active), .irq(irq)
  );

  always #5 hclk = ~hclk;

  // Run needs a few hundred cycles; anything near the ceiling is a hang
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_of_test();
    if (fails == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic w(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic ahb(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {28'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    `CHK(hresp, 1'b0)
  endtask

  task automatic rchk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    `CHK(rd & m, e)
  endtask

  task automatic outs(input logic s);
    `CHK({near_shutdown_out_a, near_shutdown_out_b, led_green}, {3{s}})
  endtask

  function automatic logic exp_cfg(input int m, input logic [2:0] v);
    if (v[2]) begin
      return 1'b0;
    end
    case (m)
      0: return ~v[0];
      1: return ~v[1];
      2: return ~|v[1:0];
      default: return 1'b1;
    endcase
  endfunction

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    int n;
    int v;
    logic flt;
    void'($urandom(36435));
    w(20);
    hresetn <= 1'b1;
    w(2);
    rchk(`RAC_OFF_CTRL, 32'hf, `RAC_CTRL_RESET);
    rchk(`RAC_OFF_STATUS, 32'h1ff, 32'h22);
    `CHK(field_pair_active, 4'h1)
    rac_button_model_i.press(8);
    w(3);
    outs(1'b0);
    rchk(`RAC_OFF_STATUS, 32'h2, 32'h2);
    ahb(1'b1, `RAC_OFF_IRQ_MASK, 32'h1f);
    sel <= 4'h1;
    w(3);
    outs(1'b0);
    rchk(`RAC_OFF_STATUS, 32'h3, 32'h3);
    // Pulses one cycle outside the window on either side
    rac_button_model_i.press(MINC - 1);
    w(3);
    outs(1'b0);
    rac_button_model_i.press(MAXC + 1);
    w(3);
    outs(1'b0);
    rchk(`RAC_OFF_IRQ_STAT, 32'h3, 32'h2);
    `CHK(irq, 1'b1)
    ahb(1'b1, `RAC_OFF_IRQ_MASK, 32'h0);
    w(2);
    `CHK(irq, 1'b0)
    ahb(1'b1, `RAC_OFF_IRQ_STAT, 32'h1f);
    ahb(1'b1, `RAC_OFF_IRQ_MASK, 32'h1f);
    w(2);
    `CHK(irq, 1'b0)
    // Window edges first, then random lengths; the last keeps the object present
    for (int i = 0; i < 4; i++) begin
      n = (i == 0) ? MINC : (i == 1) ? MAXC : MINC + $urandom % (MAXC - MINC + 1);
      dev_in.near_obj <= 1'b1;
      w(3);
      outs(1'b0);
      dev_in.near_obj <= (i == 3);
      w(3);
      outs(1'b0);
      fork
        rac_button_model_i.press(n);
        begin
          w(3);
          `CHK({led3_red, near_shutdown_out_a, near_shutdown_out_b}, 3'b100)
        end
      join
      w(3);
      outs(i != 3);
    end
    dev_in.near_obj <= 1'b0;
    rac_button_model_i.press(MINC + 1);
    w(3);
    outs(1'b1);
    // Outputs are up here, so the press must visibly pull them down
    fork
      rac_button_model_i.press(MINC);
      begin
        w(3);
        `CHK({led3_red, near_shutdown_out_a, near_shutdown_out_b}, 3'b100)
      end
    join
    rchk(`RAC_OFF_STATUS, 32'h6, 32'h0);
    rchk(`RAC_OFF_IRQ_STAT, 32'h1, 32'h1);
    for (int m = 0; m < 5; m++) begin
      ahb(1'b1, `RAC_OFF_CTRL, 32'h8 | m);
      for (v = 0; v < 8; v++) begin
        dev_in <= rac_dev_in_t'({v[2:0], 1'b0});
        w(3);
        `CHK(error_alarm_out, ~|v[2:1])
        `CHK(config_alarm_out, exp_cfg(m, v[2:0]))
        if (v[2]) `CHK({near_shutdown_out_a, near_shutdown_out_b}, 2'b00)
      end
    end
    // Without restart-disable mode the shutdown outputs follow the near field alone
    ahb(1'b1, `RAC_OFF_CTRL, 32'h4);
    dev_in <= 4'h1;
    w(3);
    outs(1'b0);
    dev_in <= 4'h0;
    w(3);
    outs(1'b1);
    supply_ok <= 1'b0;
    w(3);
    outs(1'b0);
    rchk(`RAC_OFF_STATUS, 32'h1, 32'h0);
    supply_ok <= 1'b1;
    // Supply drop left start-disable armed; release it so the sweep sees live outputs
    rchk(`RAC_OFF_STATUS, 32'h2, 32'h2);
    rac_button_model_i.press(MINC);
    w(3);
    outs(1'b1);
    // Corner combinations first, then random selects
    for (int k = 0; k < 12; k++) begin
      v = (k < 2) ? 15 - k : $urandom % 16;
      sel <= v[3:0];
      w(3);
      flt = $countones(v[3:0]) > 2;
      `CHK(field_pair_active, (v == 0) ? 4'h1 : v[3:0])
      `CHK(error_alarm_out, ~flt)
      if (flt) `CHK({near_shutdown_out_a, near_shutdown_out_b, config_alarm_out}, 3'b000)
      `CHK({near_shutdown_out_a, near_shutdown_out_b}, {2{v[3:0] != 4'h0 && !flt}})
    end
    rchk(`RAC_OFF_IRQ_STAT, 32'h1c, 32'h1c);
    `CHK(irq, 1'b1)
    end_of_test();
  end
endmodule
